/* File: inc/port_mode_consts.vh */
`ifndef PORT_MODE_CONSTS_VH
`define PORT_MODE_CONSTS_VH
`define PORT_W 8
`define PORTD_W 3
`define CFG_RESET 8'h00
`define PERIPH_BUF_BIT 7
`define BUS_MUX_GENERIC 2'h0
`define BUS_MUX_PAGED 2'h1
`define BUS_MUX_NARROW 2'h2
`define BUS_NONMUX 2'h3
`define REG_SEL_DOUT 2'h0
`define REG_SEL_DIR 2'h1
`define REG_SEL_CTRL 2'h2
`define REG_SEL_DRIVE 2'h3
`define NUM_PORTS 4
`endif

/* File: rtl/port_reg_bank.v */
`include "port_mode_consts.vh"
// small bank of per-port byte registers, one write and one registered read
module port_reg_bank (
  input wire clk,
  input wire rst_n,
  input wire wrEn,
  input wire [1:0] wrPort,
  input wire [7:0] wrData,
  input wire [1:0] rdPort,
  output reg [7:0] rdData_ff,
  output wire [31:0] allData
);
  reg [7:0] mem_ff [0:3];
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g = g + 1) begin : gMem
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_ff[g] <= `CFG_RESET;
        end else if (wrEn && wrPort == g) begin
          mem_ff[g] <= wrData;
        end
      end
      assign allData[g*8+7:g*8] = mem_ff[g];
    end
  endgenerate
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= `CFG_RESET;
    end else begin
      rdData_ff <= mem_ff[rdPort];
    end
  end
endmodule

/* File: rtl/port_mode_mux.v */
`include "port_mode_consts.vh"
module port_mode_mux (
  input wire clk,
  input wire rst_n,
  input wire hostWr,
  input wire [1:0] hostRegSel,
  input wire [1:0] hostPort,
  input wire [7:0] hostWrData,
  input wire hostRd,
  input wire [1:0] hostRdSrc,
  output reg [7:0] hostRdData_ff,
  input wire [7:0] hostDataOut,
  output reg [7:0] hostDataIn_ff,
  input wire hostDataDrive,
  input wire [7:0] peripheral_mode_reg,
  input wire periph_select_a,
  input wire periph_select_b,
  input wire [1:0] busType,
  input wire dataPortCfg,
  input wire [15:0] hostAddr,
  input wire address_latch_strobe,
  input wire [31:0] arrayAssign,
  input wire [31:0] arrayOe,
  input wire [31:0] addrInCfg,
  input wire [7:0] macrocell_group_one_a,
  input wire [7:0] macrocell_group_one_b,
  input wire [7:0] macrocell_group_two_b,
  input wire [7:0] macrocell_group_two_c,
  input wire [2:0] chipSelOut,
  input wire [2:0] scanSelect,
  input wire normalOp,
  output wire scanPinsEn,
  input wire [31:0] pinIn,
  output reg [31:0] pinOut_ff,
  output reg [31:0] pinOe_ff,
  output wire [31:0] arrayIn,
  output reg [31:0] input_macrocell_ff,
  output wire [31:0] driveSel
);
  wire [31:0] doutAll;
  wire [31:0] dirAll;
  wire [31:0] ctrlAll;
  reg [31:0] pinS1_ff;
  reg [31:0] pinS2_ff;
  reg [31:0] pinS3_ff;
  reg [31:0] pinStable_ff;
  reg strobeS1_ff;
  reg strobeS2_ff;
  reg strobeS3_ff;
  reg strobeStable_ff;
  reg strobePrev_ff;
  reg [15:0] addrLatch_ff;
  reg [31:0] nxt_pinOut;
  reg [31:0] nxt_pinOe;
  wire strobeRise;
  wire periphMode;
  wire periphActive;
  wire [31:0] dirEff;
  wire [7:0] ctrlWrMask;
  reg [15:0] addrOut;

  // write strobe aimed at one register kind
  function wr_hit;
    input wr;
    input [1:0] sel;
    input [1:0] want;
    begin
      wr_hit = wr && (sel == want);
    end
  endfunction

  // ports three and four have no mode-select; writes there store zero
  assign ctrlWrMask = (hostPort == 2'h0 || hostPort == 2'h1) ? 8'hFF : 8'h00;

  // host reads use the flat copies, so the banks' registered read ports stay unused
  port_reg_bank uDout (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wr_hit(hostWr, hostRegSel, `REG_SEL_DOUT)),
    .wrPort(hostPort),
    .wrData(hostWrData),
    .rdPort(hostPort),
    .rdData_ff(),
    .allData(doutAll)
  );

  port_reg_bank uDir (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wr_hit(hostWr, hostRegSel, `REG_SEL_DIR)),
    .wrPort(hostPort),
    .wrData(hostWrData),
    .rdPort(hostPort),
    .rdData_ff(),
    .allData(dirAll)
  );

  // only ports one and two keep control bits; the mask stores zero elsewhere
  port_reg_bank uCtrl (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wr_hit(hostWr, hostRegSel, `REG_SEL_CTRL)),
    .wrPort(hostPort),
    .wrData(hostWrData & ctrlWrMask),
    .rdPort(hostPort),
    .rdData_ff(),
    .allData(ctrlAll)
  );

  // drive select only feeds the pad cells; this block never reads it
  port_reg_bank uDrv (
    .clk(clk),
    .rst_n(rst_n),
    .wrEn(wr_hit(hostWr, hostRegSel, `REG_SEL_DRIVE)),
    .wrPort(hostPort),
    .wrData(hostWrData),
    .rdPort(hostPort),
    .rdData_ff(),
    .allData(driveSel)
  );

  // pin and strobe synchronisers; only stages two and three are compared
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinS1_ff <= 32'h00000000;
      pinS2_ff <= 32'h00000000;
      pinS3_ff <= 32'h00000000;
      strobeS1_ff <= 1'b0;
      strobeS2_ff <= 1'b0;
      strobeS3_ff <= 1'b0;
      strobeStable_ff <= 1'b0;
      strobePrev_ff <= 1'b0;
    end else begin
      pinS1_ff <= pinIn;
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      strobeS1_ff <= address_latch_strobe;
      strobeS2_ff <= strobeS1_ff;
      strobeS3_ff <= strobeS2_ff;
      if (strobeS2_ff == strobeS3_ff) begin
        strobeStable_ff <= strobeS2_ff;
      end
      strobePrev_ff <= strobeStable_ff;
    end
  end
  // edge taken from the agreed level, so a strobe shorter than two clocks is lost
  assign strobeRise = strobeStable_ff && !strobePrev_ff;
  assign arrayIn = pinStable_ff;

  // a pin level is taken, rising or falling, only once stages two and three agree
  genvar b;
  generate
    for (b = 0; b < 32; b = b + 1) begin : gPinDeb
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pinStable_ff[b] <= 1'b0;
        end else if (pinS2_ff[b] == pinS3_ff[b]) begin
          pinStable_ff[b] <= pinS2_ff[b];
        end
      end
    end
  endgenerate

  // address inputs and the output address latch both capture on the strobe
  // hostAddr must be steady around the strobe; it is not synchronised here
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      input_macrocell_ff <= 32'h00000000;
      addrLatch_ff <= 16'h0000;
    end else if (strobeRise) begin
      input_macrocell_ff <= (input_macrocell_ff & ~addrInCfg) | (pinStable_ff & addrInCfg);
      addrLatch_ff <= hostAddr;
    end
  end

  // nibble placement per bus type: {port two, port one}
  always @* begin
    case (busType)
      `BUS_MUX_PAGED: begin
        addrOut = {addrLatch_ff[15:8], 8'h00};
      end
      `BUS_MUX_NARROW: begin
        // a7-a4 on the high nibble of port one, a11-a8 on the low nibble of port two
        addrOut = {4'h0, addrLatch_ff[11:8], addrLatch_ff[7:4], 4'h0};
      end
      `BUS_NONMUX: begin
        addrOut = {addrLatch_ff[7:0], 8'h00};
      end
      default: begin
        addrOut = {addrLatch_ff[7:0], addrLatch_ff[7:0]};
      end
    endcase
  end

  // port four keeps only three direction bits
  assign dirEff = {5'h00, dirAll[26:24], dirAll[23:0]};
  assign periphMode = peripheral_mode_reg[`PERIPH_BUF_BIT];
  assign periphActive = periph_select_a || periph_select_b;
  assign scanPinsEn = (|scanSelect) && !normalOp;

  integer i;
  always @* begin
    nxt_pinOut = 32'h00000000;
    nxt_pinOe = 32'h00000000;
    for (i = 0; i < 32; i = i + 1) begin
      // default cpu-mapped i/o, enable is direction or array oe
      nxt_pinOut[i] = doutAll[i];
      nxt_pinOe[i] = dirEff[i] | arrayOe[i];
      // address out needs its control bit; the enable still wants dir or the oe term
      if (i < 16 && ctrlAll[i]) begin
        nxt_pinOut[i] = addrOut[i];
        nxt_pinOe[i] = arrayOe[i] | (dirEff[i] & ctrlAll[i]);
      end
      if (arrayAssign[i]) begin
        // fixed array assignment wins over cpu and address modes; peripheral mode still takes port one
        if (i < 8) begin
          nxt_pinOut[i] = macrocell_group_one_a[i];
        end else if (i < 16) begin
          nxt_pinOut[i] = macrocell_group_one_b[i-8] | macrocell_group_two_b[i-8];
        end else if (i < 24) begin
          nxt_pinOut[i] = macrocell_group_two_c[i-16];
        end else if (i < 27) begin
          nxt_pinOut[i] = chipSelOut[i-24];
        end
        nxt_pinOe[i] = arrayOe[i] | dirEff[i];
      end
      // pins above bit 26 do not exist on port four; keep them released
      if (i > 26) begin
        nxt_pinOe[i] = 1'b0;
      end
      // data bus mode is fixed configuration, so it beats peripheral and cpu modes
      if (i < 8 && dataPortCfg) begin
        nxt_pinOut[i] = hostDataOut[i];
        nxt_pinOe[i] = hostDataDrive;
      end
      // released unless a select equation claims the buffer while hostDataDrive is set
      if (i < 8 && periphMode && !dataPortCfg) begin
        nxt_pinOut[i] = hostDataOut[i];
        nxt_pinOe[i] = periphActive && hostDataDrive;
      end
      if (i >= 16 && i < 24 && scanPinsEn) begin
        // scan logic owns port three while programming
        nxt_pinOe[i] = 1'b0;
      end
    end
  end

  // reads return register contents as of the cycle in which hostRd is seen
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut_ff <= 32'h00000000;
      pinOe_ff <= 32'h00000000;
      hostDataIn_ff <= 8'h00;
      hostRdData_ff <= 8'h00;
    end else begin
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= nxt_pinOe;
      // port one pin level feeds the host data bus in data and peripheral modes
      hostDataIn_ff <= pinStable_ff[7:0];
      if (hostRd) begin
        case (hostRdSrc)
          2'h0: begin
            hostRdData_ff <= pinStable_ff[hostPort*8 +: 8];
          end
          2'h1: begin
            hostRdData_ff <= doutAll[hostPort*8 +: 8];
          end
          2'h2: begin
            if (hostPort == 2'h3) begin
              hostRdData_ff <= dirAll[31:24] & 8'h07;
            end else begin
              hostRdData_ff <= dirAll[hostPort*8 +: 8];
            end
          end
          default: begin
            hostRdData_ff <= ctrlAll[hostPort*8 +: 8];
          end
        endcase
      end
    end
  end
endmodule

/* File: verification/port_mode_mux_assertions.sv */
module port_mode_mux_assertions (
  input wire clk,
  input wire rst_n,
  input wire hostWr,
  input wire [1:0] hostRegSel,
  input wire [1:0] hostPort,
  input wire [7:0] hostWrData,
  input wire hostRd,
  input wire [1:0] hostRdSrc,
  input wire [7:0] hostRdData_ff,
  input wire [7:0] hostDataOut,
  input wire hostDataDrive,
  input wire [7:0] peripheral_mode_reg,
  input wire periph_select_a,
  input wire periph_select_b,
  input wire dataPortCfg,
  input wire [31:0] arrayOe,
  input wire [2:0] scanSelect,
  input wire normalOp,
  input wire scanPinsEn,
  input wire [31:0] pinOut_ff,
  input wire [31:0] pinOe_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_SCAN_EN: assert property (scanPinsEn == (|scanSelect & !normalOp))
    else $error("scan enable wrong");
  AST_SCAN_TRI: assert property (scanPinsEn |=> pinOe_ff[23:16] == 8'h00)
    else $error("port three driven in scan");
  AST_D_HIGH_OFF: assert property (pinOe_ff[31:27] == 5'h00)
    else $error("port four upper enable set");
  AST_CTRL_CD_ZERO: assert property (hostRd && hostRdSrc == 2'h3 && hostPort[1]
    |=> hostRdData_ff == 8'h00) else $error("ctrl of port three or four not zero");
  AST_DIR_D_READ: assert property (hostRd && hostRdSrc == 2'h2 && hostPort == 2'h3
    |=> hostRdData_ff[7:3] == 5'h00) else $error("port four dir upper bits read");
  AST_DIR_OE: assert property (hostWr && hostRegSel == 2'h1 && hostPort == 2'h1 ##1 !hostWr
    |=> (pinOe_ff[15:8] | ~$past(hostWrData, 2)) == 8'hFF) else $error("dir not enabling");
  AST_ARRAY_OE: assert property (!scanPinsEn && arrayOe[23:16] == 8'hFF
    |=> pinOe_ff[23:16] == 8'hFF) else $error("array enable ignored");
  AST_PERIPH_TRI: assert property (peripheral_mode_reg[7] && !dataPortCfg
    && !periph_select_a && !periph_select_b |=> pinOe_ff[7:0] == 8'h00)
    else $error("peripheral buffer not tri-stated");
  AST_DATA_PORT: assert property (dataPortCfg && hostDataDrive
    |=> pinOut_ff[7:0] == $past(hostDataOut)) else $error("data port output wrong");
  cover property (hostWr && hostRegSel == 2'h1);
  cover property (scanPinsEn);
  cover property (peripheral_mode_reg[7] && periph_select_a);
endmodule

/* File: verification/pin_far_end.sv */
module pin_far_end (
  input wire [31:0] pinOut_ff,
  input wire [31:0] pinOe_ff,
  input wire [31:0] extDrive,
  output wire [31:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pins take the external level, so none reads back a stale value
  assign pinIn = (pinOe_ff & pinOut_ff) | (~pinOe_ff & extDrive);
endmodule

/* File: verification/port_mode_mux_tb.sv */
module port_mode_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = '0, rst_n = '0, hostWr = '0, hostRd = '0, hostDataDrive = '0, dataPortCfg = '0;
  logic periph_select_a = '0, periph_select_b = '0, address_latch_strobe = '0, normalOp = '1;
  logic [1:0] hostRegSel = '0, hostPort = '0, hostRdSrc = '0, busType = '0;
  logic [2:0] chipSelOut = '0, scanSelect = '0;
  logic [7:0] hostWrData = '0, hostDataOut = '0, peripheral_mode_reg = '0, rv;
  logic [7:0] macrocell_group_one_a = '0, macrocell_group_one_b = '0, macrocell_group_two_b = '0;
  logic [7:0] macrocell_group_two_c = '0, hostRdData_ff, hostDataIn_ff;
  logic [7:0] expB [4] = '{8'hEF, 8'hBE, 8'h0E, 8'hEF};
  logic [15:0] hostAddr = 16'hBEEF;
  logic [31:0] arrayAssign = '0, arrayOe = '0, addrInCfg = '0, extDrive = '0, pinIn, pinOut_ff;
  logic [31:0] pinOe_ff, arrayIn, input_macrocell_ff, driveSel;
  logic scanPinsEn;
  int failures = 0, compares = 0, cyc = 0;
  port_mode_mux DUT (.*);
  pin_far_end far (.*);
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic wrReg(input logic [1:0] s, p, input logic [7:0] d);
    @(posedge clk) #1;
    {hostWr, hostRegSel, hostPort, hostWrData} = {1'b1, s, p, d};
    @(posedge clk) #1 hostWr = '0;
  endtask
  task automatic rdReg(input logic [1:0] s, p);
    @(posedge clk) #1;
    {hostRd, hostRdSrc, hostPort} = {1'b1, s, p};
    @(posedge clk) #1 hostRd = '0;
    rv = hostRdData_ff;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ceiling well above the roughly 125 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      conclude;
    end
  end
  initial begin
    waitc(10);
    rst_n = '1;
    chk("reset oe", 32'h0, pinOe_ff);
    chk("reset drive", 32'h0, driveSel);
    for (int p = 0; p < 4; p++) begin
      for (int s = 1; s < 4; s++) begin
        rdReg(s[1:0], p[1:0]);
        chk("reset reg", 32'h0, rv);
      end
    end
    $display("reset test done");
    wrReg(2'h0, 2'h1, 8'hA5);
    wrReg(2'h1, 2'h1, 8'hFF);
    rdReg(2'h1, 2'h1);
    chk("dout back", 8'hA5, rv);
    chk("port two out", 8'hA5, pinOut_ff[15:8]);
    chk("port two oe", 8'hFF, pinOe_ff[15:8]);
    extDrive = 32'h003C0000;
    waitc(6);
    rdReg(2'h0, 2'h2);
    chk("pin in", 8'h3C, rv);
    wrReg(2'h1, 2'h3, 8'hFF);
    rdReg(2'h2, 2'h3);
    chk("port four dir", 8'h07, rv);
    chk("port four oe", 8'h07, pinOe_ff[31:24]);
    wrReg(2'h2, 2'h2, 8'hFF);
    rdReg(2'h3, 2'h2);
    chk("port three ctrl", 8'h00, rv);
    $display("cpu io test done");
    wrReg(2'h2, 2'h0, 8'hFF);
    wrReg(2'h1, 2'h0, 8'hFF);
    wrReg(2'h2, 2'h1, 8'hFF);
    address_latch_strobe = '1;
    waitc(8);
    address_latch_strobe = '0;
    waitc(3);
    chk("addr port one", 8'hEF, pinOut_ff[7:0]);
    for (int t = 0; t < 4; t++) begin
      busType = t[1:0];
      waitc(3);
      chk("addr port two", expB[t], pinOut_ff[15:8] & ((t == 2) ? 8'h0F : 8'hFF));
    end
    $display("address out test done");
    {dataPortCfg, hostDataDrive, hostDataOut} = {2'h3, 8'h5A};
    waitc(3);
    chk("data port", 8'h5A, pinOut_ff[7:0]);
    dataPortCfg = '0;
    peripheral_mode_reg = 8'h80;
    waitc(3);
    chk("periph idle", 8'h00, pinOe_ff[7:0]);
    periph_select_b = '1;
    waitc(3);
    chk("periph out", 8'h5A, pinOut_ff[7:0] & pinOe_ff[7:0]);
    {peripheral_mode_reg, periph_select_b, hostDataDrive} = '0;
    $display("data port test done");
    wrReg(2'h1, 2'h2, 8'hFF);
    {scanSelect, normalOp} = 4'h8;
    waitc(3);
    chk("scan en", 32'h1, scanPinsEn);
    chk("scan oe", 8'h00, pinOe_ff[23:16]);
    {scanSelect, normalOp} = 4'h1;
    $display("scan test done");
    // cleared first so no array input pin still has its direction set
    wrReg(2'h1, 2'h2, 8'h00);
    {arrayAssign, arrayOe} = {2{32'h07FF00FF}};
    {macrocell_group_one_a, macrocell_group_two_c, chipSelOut} = {8'hC3, 8'h96, 3'h5};
    waitc(3);
    chk("array out", 32'h059600C3, pinOut_ff & 32'h07FF00FF);
    chk("array oe", 32'h07FF00FF, pinOe_ff & 32'h07FF00FF);
    arrayOe = '0;
    waitc(3);
    chk("array tri", 8'h00, pinOe_ff[23:16]);
    $display("array test done");
    extDrive = 32'h00A50000;
    addrInCfg = 32'h00FF0000;
    waitc(6);
    chk("array in", 8'hA5, arrayIn[23:16]);
    chk("data in", 8'hC3, hostDataIn_ff);
    address_latch_strobe = '1;
    waitc(8);
    address_latch_strobe = '0;
    waitc(3);
    chk("addr in", 32'h00A50000, input_macrocell_ff);
    $display("address in test done");
    conclude;
  end
endmodule
bind port_mode_mux port_mode_mux_assertions chk (.*);
